// >>> rtl/adc_consts.vh
`ifndef ADC_CONSTS_VH
`define ADC_CONSTS_VH

// clock rate and documented times
`define ADC_CLK_MHZ          50
`define ADC_SETTLE_US        11
`define ADC_SETTLE_SHORT_US  8
`define ADC_HOLD_US          2
`define ADC_CONV_US          20
`define ADC_REACQ_US         4
`define ADC_RES_BITS         10
`define ADC_DEV_W            6

// derived cycle counts
`define ADC_SETTLE_CYC       (`ADC_SETTLE_US * `ADC_CLK_MHZ)
`define ADC_SETTLE_SHORT_CYC (`ADC_SETTLE_SHORT_US * `ADC_CLK_MHZ)
`define ADC_HOLD_CYC         (`ADC_HOLD_US * `ADC_CLK_MHZ)
`define ADC_BIT_CYC          (`ADC_CONV_US * `ADC_CLK_MHZ / `ADC_RES_BITS)
`define ADC_REACQ_CYC        (`ADC_REACQ_US * `ADC_CLK_MHZ)

// register map, byte addresses
`define ADC_ADDR_W           4
`define ADC_CMD_OFS          4'h0
`define ADC_REPLY_OFS        4'h4
`define ADC_STATE_OFS        4'h8

// command word fields
`define ADC_CMD_FN_LSB       12
`define ADC_CMD_DEV_LSB      15

// instruction functions
`define ADC_FN_CLEAR         3'h0
`define ADC_FN_LOAD_MUX      3'h1
`define ADC_FN_START         3'h2
`define ADC_FN_READ_BUF      3'h3
`define ADC_FN_SKIP_DONE     3'h4
`define ADC_FN_SKIP_ERR      3'h5
`define ADC_FN_LOAD_EN       3'h6
`define ADC_FN_READ_REGS     3'h7

// enable field positions in the accumulator word
`define ADC_EN_LSB           5
`define ADC_EN_MSB           9

// enable register bit positions
`define ADC_EN_UNI           0
`define ADC_EN_INC           1
`define ADC_EN_EXT           2
`define ADC_EN_ERR_IE        3
`define ADC_EN_DONE_IE       4

// responses, reset values and result buffer size
`define ADC_RESP_OKAY        2'h0
`define ADC_RESP_SLVERR      2'h2
`define ADC_PIN_RST          10'h001
`define ADC_FIFO_DEPTH       32
`define ADC_FIFO_AW          5

`endif

// >>> rtl/adc_fifo.v
`timescale 1ns/1ps
`default_nettype none

module adc_fifo #(
    parameter WIDTH = 12,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             aclk,
    input  wire             aresetn,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      count_q;

    localparam [AW:0] FULL = DEPTH[AW:0];

    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;

    assign in_ready  = (count_q != FULL);
    assign out_valid = (count_q != {(AW+1){1'b0}});
    assign out_data  = mem[rd_q];

    always @(posedge aclk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            wr_q    <= {AW{1'b0}};
            rd_q    <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push & ~pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop & ~push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// >>> rtl/adc_ctl.v
`timescale 1ns/1ps
`default_nettype none
`include "adc_consts.vh"

module adc_ctl (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [5:0]  device_code,
    input  wire        external_trigger_n,
    input  wire        rtc_overflow,
    input  wire        settle_shorten_jumper,
    input  wire        comp_in,
    output reg  [3:0]  mux_sel,
    output reg         unipolar,
    output reg         sh_hold,
    output reg  [9:0]  dac_code,
    output reg         irq
);
    localparam [2:0] ST_IDLE   = 3'h0;
    localparam [2:0] ST_SETTLE = 3'h1;
    localparam [2:0] ST_HOLD   = 3'h2;
    localparam [2:0] ST_CONV   = 3'h3;
    localparam [2:0] ST_STORE  = 3'h4;
    localparam [2:0] ST_REACQ  = 3'h5;

    // counts stay integer here and are cut to the timer width where used
    localparam integer SETTLE_CYC = `ADC_SETTLE_CYC;
    localparam integer SHORT_CYC  = `ADC_SETTLE_SHORT_CYC;
    localparam integer HOLD_CYC   = `ADC_HOLD_CYC;
    localparam integer BIT_CYC    = `ADC_BIT_CYC;
    localparam integer REACQ_CYC  = `ADC_REACQ_CYC;
    localparam [9:0] PIN_RST    = `ADC_PIN_RST;

    // pin synchronisers, two flops each
    wire [9:0] pin_raw;
    wire [9:0] pin_s;
    assign pin_raw = {device_code, comp_in, settle_shorten_jumper,
                      rtc_overflow, external_trigger_n};
    genvar gi;
    generate
        for (gi = 0; gi < 10; gi = gi + 1) begin : g_sync
            reg meta_q;
            reg sync_q;
            always @(posedge aclk) begin
                if (!aresetn) begin
                    meta_q <= PIN_RST[gi];
                    sync_q <= PIN_RST[gi];
                end else begin
                    meta_q <= pin_raw[gi];
                    sync_q <= meta_q;
                end
            end
            assign pin_s[gi] = sync_q;
        end
    endgenerate

    wire       ext_s   = pin_s[0];
    wire       rtc_s   = pin_s[1];
    wire       short_s = pin_s[2];
    wire       comp_s  = pin_s[3];
    wire [5:0] dev_s   = pin_s[9:4];

    reg        ext_prev_q;
    reg        rtc_prev_q;
    reg        aw_got_q;
    reg        w_got_q;
    reg [3:0]  awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0]  wstrb_q;
    reg [2:0]  state_q;
    reg [9:0]  timer_q;
    reg [3:0]  bit_q;
    reg        reacq_q;
    reg        conv_uni_q;
    reg        done_q;
    reg        err_q;
    reg [4:0]  enable_q;
    reg [11:0] ac_q;
    reg        skip_q;
    reg        match_q;
    reg        done_d;
    reg        err_d;

    wire ext_fall = ext_prev_q & ~ext_s;
    wire rtc_rise = rtc_s & ~rtc_prev_q;

    // command decode
    wire        wr_go   = aw_got_q & w_got_q & ~s_axi_bvalid;
    wire        cmd_hit = wr_go & (awaddr_q == `ADC_CMD_OFS);
    wire [2:0]  fn      = wdata_q[`ADC_CMD_FN_LSB +: 3];
    wire [5:0]  cmd_dev = wdata_q[`ADC_CMD_DEV_LSB +: `ADC_DEV_W];
    wire [11:0] acin    = wdata_q[11:0];
    wire        dev_ok  = (cmd_dev == dev_s);
    wire        cmd_go  = cmd_hit & (&wstrb_q[2:0]) & dev_ok;
    wire fn_clear = cmd_go & (fn == `ADC_FN_CLEAR);
    wire fn_lmux  = cmd_go & (fn == `ADC_FN_LOAD_MUX);
    wire fn_start = cmd_go & (fn == `ADC_FN_START);
    wire fn_read  = cmd_go & (fn == `ADC_FN_READ_BUF);
    wire fn_len   = cmd_go & (fn == `ADC_FN_LOAD_EN);

    // start sources
    wire hw_start = enable_q[`ADC_EN_EXT] & (ext_fall | rtc_rise);
    wire any_start = fn_start | hw_start;
    wire busy      = (state_q != ST_IDLE);

    // result buffer path
    wire        fifo_in_ready;
    wire        fifo_out_valid;
    wire [11:0] fifo_out_data;
    wire        push = (state_q == ST_STORE) & fifo_in_ready;
    wire [11:0] result = conv_uni_q ? {2'b00, dac_code} :
                         {{3{~dac_code[9]}}, dac_code[8:0]};

    adc_fifo #(
        .WIDTH (12),
        .DEPTH (`ADC_FIFO_DEPTH),
        .AW    (`ADC_FIFO_AW)
    ) u_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (state_q == ST_STORE),
        .in_ready  (fifo_in_ready),
        .in_data   (result),
        .out_valid (fifo_out_valid),
        .out_ready (fn_read),
        .out_data  (fifo_out_data)
    );

    // flags: a hardware set wins over a clear in the same cycle
    always @* begin
        done_d = done_q;
        err_d  = err_q;
        if (fn_clear | fn_start | fn_read) begin
            done_d = 1'b0;
        end
        if (fn_clear | fn_start) begin
            err_d = 1'b0;
        end
        if (push) begin
            done_d = 1'b1;
        end
        if ((any_start & busy) | (push & fn_read)) begin
            err_d = 1'b1;
        end
    end

    // register bus slave
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `ADC_RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `ADC_RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
            aw_got_q      <= 1'b0;
            w_got_q       <= 1'b0;
            awaddr_q      <= 4'h0;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                awaddr_q      <= s_axi_awaddr;
                aw_got_q      <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                w_got_q      <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                if (awaddr_q == `ADC_CMD_OFS ||
                    awaddr_q == `ADC_REPLY_OFS ||
                    awaddr_q == `ADC_STATE_OFS) begin
                    s_axi_bresp <= `ADC_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `ADC_RESP_SLVERR;
                end
            end
            if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_got_q      <= 1'b0;
                w_got_q       <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `ADC_RESP_OKAY;
                case (s_axi_araddr)
                    `ADC_CMD_OFS: begin
                        s_axi_rdata <= 32'h0000_0000;
                    end
                    `ADC_REPLY_OFS: begin
                        s_axi_rdata <= {18'h00000, match_q, skip_q, ac_q};
                    end
                    `ADC_STATE_OFS: begin
                        s_axi_rdata <= {24'h000000, ~fifo_in_ready,
                                        fifo_out_valid, busy, 2'b00,
                                        state_q};
                    end
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `ADC_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // program-visible registers and instruction replies
    always @(posedge aclk) begin
        if (!aresetn) begin
            done_q   <= 1'b0;
            err_q    <= 1'b0;
            enable_q <= 5'h00;
            mux_sel  <= 4'h0;
            unipolar <= 1'b0;
            ac_q     <= 12'h000;
            skip_q   <= 1'b0;
            match_q  <= 1'b0;
            irq      <= 1'b0;
        end else begin
            done_q   <= done_d;
            err_q    <= err_d;
            unipolar <= enable_q[`ADC_EN_UNI];
            irq <= (done_q & enable_q[`ADC_EN_DONE_IE]) |
                   (err_q & enable_q[`ADC_EN_ERR_IE]);
            if (fn_clear) begin
                enable_q <= 5'h00;
                mux_sel  <= 4'h0;
            end else if (fn_lmux) begin
                mux_sel <= acin[3:0];
            end else if (push & enable_q[`ADC_EN_INC]) begin
                mux_sel <= mux_sel + 4'h1;
            end
            if (fn_len) begin
                enable_q <= acin[`ADC_EN_MSB:`ADC_EN_LSB];
            end
            if (cmd_hit) begin
                match_q <= dev_ok;
            end
            if (cmd_go) begin
                skip_q <= 1'b0;
                case (fn)
                    `ADC_FN_LOAD_MUX, `ADC_FN_LOAD_EN: begin
                        ac_q <= 12'h000;
                    end
                    `ADC_FN_READ_BUF: begin
                        ac_q <= fifo_out_valid ? fifo_out_data : 12'h000;
                    end
                    `ADC_FN_SKIP_DONE: begin
                        skip_q <= done_q;
                    end
                    `ADC_FN_SKIP_ERR: begin
                        skip_q <= err_q;
                    end
                    `ADC_FN_READ_REGS: begin
                        ac_q <= {done_q, err_q, enable_q, 1'b0, mux_sel};
                    end
                    default: begin
                        ac_q <= ac_q;
                    end
                endcase
            end
        end
    end

    // conversion sequencer
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q    <= ST_IDLE;
            timer_q    <= 10'h000;
            bit_q      <= 4'h0;
            reacq_q    <= 1'b0;
            conv_uni_q <= 1'b0;
            dac_code   <= 10'h000;
            sh_hold    <= 1'b0;
            ext_prev_q <= 1'b1;
            rtc_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= ext_s;
            rtc_prev_q <= rtc_s;
            case (state_q)
                ST_IDLE: begin
                    if (any_start) begin
                        state_q    <= ST_SETTLE;
                        reacq_q    <= ~fn_start;
                        conv_uni_q <= enable_q[`ADC_EN_UNI];
                        timer_q <= short_s ? SHORT_CYC[9:0] - 10'h001 :
                                   SETTLE_CYC[9:0] - 10'h001;
                    end
                end
                ST_SETTLE: begin
                    if (timer_q == 10'h000) begin
                        state_q <= ST_HOLD;
                        sh_hold <= 1'b1;
                        timer_q <= HOLD_CYC[9:0] - 10'h001;
                    end else begin
                        timer_q <= timer_q - 10'h001;
                    end
                end
                ST_HOLD: begin
                    if (timer_q == 10'h000) begin
                        state_q  <= ST_CONV;
                        dac_code <= 10'h200;
                        bit_q    <= 4'h9;
                        timer_q  <= BIT_CYC[9:0] - 10'h001;
                    end else begin
                        timer_q <= timer_q - 10'h001;
                    end
                end
                ST_CONV: begin
                    if (timer_q == 10'h000) begin
                        // comparator low means trial bit overshoots
                        dac_code <= (comp_s ? dac_code :
                                     dac_code & ~(10'h001 << bit_q)) |
                                    ((10'h001 << bit_q) >> 1);
                        timer_q  <= BIT_CYC[9:0] - 10'h001;
                        if (bit_q == 4'h0) begin
                            state_q <= ST_STORE;
                        end else begin
                            bit_q <= bit_q - 4'h1;
                        end
                    end else begin
                        timer_q <= timer_q - 10'h001;
                    end
                end
                ST_STORE: begin
                    // a full buffer stalls here rather than drop a result
                    if (fifo_in_ready) begin
                        sh_hold <= 1'b0;
                        if (reacq_q) begin
                            state_q <= ST_REACQ;
                            timer_q <= REACQ_CYC[9:0] - 10'h001;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_REACQ: begin
                    if (timer_q == 10'h000) begin
                        state_q <= ST_IDLE;
                    end else begin
                        timer_q <= timer_q - 10'h001;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

`default_nettype wire

// >>> testbench/adc_ctl_chk.sv
`timescale 1ns/1ps
`default_nettype none

module adc_ctl_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic [3:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic [3:0]  mux_sel,
    input wire logic        unipolar,
    input wire logic        sh_hold
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // sampled high cycles of the hold strobe; store may stretch it a little
    logic [11:0] hold_cnt_q;
    always @(posedge aclk) begin
        if (!aresetn || !sh_hold) begin
            hold_cnt_q <= 12'h000;
        end else begin
            hold_cnt_q <= hold_cnt_q + 12'h001;
        end
    end

    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence hold_end;
        $fell(sh_hold);
    endsequence

    rst_idle_a: assert property (disable iff (1'b0) !aresetn |=>
        s_axi_awready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid
        && mux_sel == 4'h0 && !unipolar && !sh_hold)
        else $error("outputs not idle after reset");
    wr_answer_a: assert property (wr_take |=> !s_axi_awready ##1
        (s_axi_bvalid && !s_axi_awready))
        else $error("write not answered in two cycles");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready)
        else $error("read not answered in one cycle");
    b_stand_a: assert property (s_axi_bvalid |=> $past(s_axi_bready) ?
        !s_axi_bvalid : (s_axi_bvalid && $stable(s_axi_bresp)))
        else $error("write response not held until taken");
    r_stand_a: assert property (s_axi_rvalid |=> $past(s_axi_rready) ?
        !s_axi_rvalid : (s_axi_rvalid && $stable(s_axi_rdata)))
        else $error("read data not held until taken");
    slv_err_a: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == 4'hc |=> s_axi_rresp == 2'h2)
        else $error("unmapped read not refused");
    hold_len_a: assert property (hold_end |->
        hold_cnt_q >= 12'h44c && hold_cnt_q <= 12'h456)
        else $error("hold plus conversion length wrong");
    range_set_a: assert property (
        $changed(unipolar) |-> $past(s_axi_bvalid)
        && !$past(s_axi_bvalid, 2))
        else $error("range moved without a command");
    chan_set_a: assert property ($changed(mux_sel) |->
        $rose(s_axi_bvalid) || sh_hold || $past(sh_hold))
        else $error("channel moved outside command or conversion end");
endmodule

bind adc_ctl adc_ctl_chk chk_i (.*);
`default_nettype wire

// >>> testbench/adc_afe_model.sv
`timescale 1ns/1ps
`default_nettype none

module adc_afe_model (
    input wire logic       aclk,
    input wire logic [3:0] mux_sel,
    input wire logic       sh_hold,
    input wire logic [9:0] dac_code,
    output logic           comp_in
);
    logic [9:0] held_q;
    logic       hold_q = 1'b0;
    logic       tog_q = 1'b0;

    // level frozen when hold starts; comparator is meaningless outside hold
    always @(posedge aclk) begin
        hold_q <= sh_hold;
        tog_q <= ~tog_q;
        if (sh_hold && !hold_q) begin
            held_q <= {mux_sel, 6'h15};
        end
    end
    assign comp_in = sh_hold ? (held_q >= dac_code) : tog_q;
endmodule
`default_nettype wire

// >>> testbench/adc_ctl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define ACHK(a, e) \
    begin \
        samples_checked++; \
        if ((a) !== (e)) begin \
            err_total++; \
            $display("[ERR] %0t got %h want %h", $time, (a), (e)); \
        end \
    end

module adc_ctl_tb_top;
    localparam logic [5:0] DEV = 6'h1d;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0;
    logic [3:0]  s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic [5:0]  device_code = DEV;
    logic        external_trigger_n = 1'b1;
    logic        rtc_overflow = 1'b0;
    logic        settle_shorten_jumper = 1'b0;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire logic   s_axi_rvalid, unipolar, sh_hold, irq, comp_in;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic [3:0]  mux_sel;
    wire logic [9:0]  dac_code;
    logic [31:0] q;
    logic [1:0]  r;
    int          t;
    int          cyc = 0;
    int          err_total = 0;
    int          samples_checked = 0;

    adc_ctl dut (.*);
    adc_afe_model afe_i (.*);

    initial begin
        forever #10 aclk = ~aclk;
    end

    function automatic logic [11:0] exp_res(input logic [3:0] ch,
                                            input logic uni);
        logic [9:0] c;
        c = {ch, 6'h15};
        exp_res = uni ? {2'b00, c} : {{3{~c[9]}}, c[8:0]};
    endfunction

    task print_verdict();
        if (err_total == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            print_verdict();
        end
    end

    // ready for the answer goes up with the request; a hang ends by timeout
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        if (w) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
        end
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(w ? s_axi_bvalid : s_axi_rvalid));
        q = s_axi_rdata;
        r = w ? s_axi_bresp : s_axi_rresp;
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
    endtask

    task cmd(input logic [5:0] dv, input logic [2:0] fn,
             input logic [11:0] ac);
        bus(1'b1, 4'h0, {11'h0, dv, fn, ac});
    endtask

    task reply(input logic [2:0] fn);
        cmd(DEV, fn, 12'h0);
        bus(1'b0, 4'h4, 32'h0);
    endtask

    // t is the number of cycles from the call to the start of hold
    task wait_conv();
        int n;
        n = 0;
        t = 0;
        while (!sh_hold && t < 900) begin
            @(posedge aclk);
            t++;
        end
        `ACHK(sh_hold, 1'b1)
        while (sh_hold && n < 3000) begin
            @(posedge aclk);
            n++;
        end
        `ACHK(sh_hold, 1'b0)
        repeat (3) @(posedge aclk);
    endtask

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        `ACHK({irq, mux_sel}, 5'h00)
        bus(1'b0, 4'h8, 32'h0);
        `ACHK(q, 32'h0)
        bus(1'b0, 4'hc, 32'h0);
        `ACHK(r, 2'h2)
        bus(1'b1, 4'hc, 32'h0);
        `ACHK(r, 2'h2)
        cmd(6'h00, 3'h1, 12'h007);
        bus(1'b0, 4'h4, 32'h0);
        `ACHK({q[13], mux_sel}, 5'h00)
        cmd(DEV, 3'h1, 12'h009);
        `ACHK(mux_sel, 4'h9)
        cmd(DEV, 3'h6, 12'h220);
        @(posedge aclk);
        `ACHK(unipolar, 1'b1)
        cmd(DEV, 3'h2, 12'h0);
        wait_conv();
        `ACHK(t > 539 && t < 561, 1'b1)
        `ACHK(irq, 1'b1)
        reply(3'h4);
        `ACHK(q[12], 1'b1)
        reply(3'h3);
        `ACHK(q[11:0], exp_res(4'h9, 1'b1))
        `ACHK(irq, 1'b0)
        settle_shorten_jumper <= 1'b1;
        cmd(DEV, 3'h6, 12'h0);
        cmd(DEV, 3'h2, 12'h0);
        wait_conv();
        `ACHK(t > 389 && t < 411, 1'b1)
        reply(3'h3);
        `ACHK(q[11:0], exp_res(4'h9, 1'b0))
        cmd(DEV, 3'h2, 12'h0);
        cmd(DEV, 3'h2, 12'h0);
        reply(3'h5);
        `ACHK(q[12], 1'b1)
        wait_conv();
        reply(3'h3);
        cmd(DEV, 3'h2, 12'h0);
        reply(3'h5);
        `ACHK(q[12], 1'b0)
        wait_conv();
        reply(3'h3);
        `ACHK(q[11:0], exp_res(4'h9, 1'b0))
        // two results queue up before either is read
        cmd(DEV, 3'h6, 12'h040);
        cmd(DEV, 3'h1, 12'h003);
        cmd(DEV, 3'h2, 12'h0);
        wait_conv();
        cmd(DEV, 3'h2, 12'h0);
        wait_conv();
        `ACHK(mux_sel, 4'h5)
        reply(3'h3);
        `ACHK(q[11:0], exp_res(4'h3, 1'b0))
        reply(3'h3);
        `ACHK(q[11:0], exp_res(4'h4, 1'b0))
        cmd(DEV, 3'h6, 12'h080);
        external_trigger_n <= 1'b0;
        wait_conv();
        bus(1'b0, 4'h8, 32'h0);
        `ACHK(q[2:0], 3'h5)
        external_trigger_n <= 1'b1;
        reply(3'h3);
        `ACHK(q[11:0], exp_res(4'h5, 1'b0))
        repeat (250) @(posedge aclk);
        rtc_overflow <= 1'b1;
        wait_conv();
        rtc_overflow <= 1'b0;
        reply(3'h3);
        `ACHK(q[11:0], exp_res(4'h5, 1'b0))
        repeat (250) @(posedge aclk);
        cmd(DEV, 3'h6, 12'h0);
        external_trigger_n <= 1'b0;
        rtc_overflow <= 1'b1;
        repeat (800) @(posedge aclk);
        bus(1'b0, 4'h8, 32'h0);
        `ACHK({q[6:5], q[2:0]}, 5'h00)
        print_verdict();
    end
endmodule
`default_nettype wire
